//--- logic/bpsc_defines.svh
`ifndef BPSC_DEFINES_SVH
`define BPSC_DEFINES_SVH
`define BPSC_MCLK_HZ 50000000
`define BPSC_OVL_LIMIT 256
`define BPSC_HICCUP_CYC 8192
`define BPSC_FALLBACK_HZ 100000
`define BPSC_FALLBACK_CNT (`BPSC_MCLK_HZ / `BPSC_FALLBACK_HZ)
`define BPSC_SYNC_MIN_HZ 250000
`define BPSC_SYNC_LOSS_CNT (2 * (`BPSC_MCLK_HZ / `BPSC_SYNC_MIN_HZ))
`define BPSC_FALLBACK_CYC 16
`define BPSC_NSYNC 9
`endif

//--- logic/bpsc_pkg.sv
package bpsc_pkg;
  typedef enum logic [3:0] {
    ST_OFF = 4'h1,
    ST_RUN = 4'h2,
    ST_HICCUP = 4'h4,
    ST_HOT = 4'h8
  } bpsc_state_t;
endpackage

//--- logic/bpsc_sync.sv
`timescale 1ns/10ps
module bpsc_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= '0;
      dout <= '0;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule

//--- logic/bpsc_top.sv
`timescale 1ns/10ps
`include "bpsc_defines.svh"
// How it works
// - Peak current reached: high side off, low side on.
// - Source limit at cycle end: skip high side, low side stays on.
// - High side resumes only at a cycle start with source limit clear.
// - Sink limit: low side off at once, both off until next start.
// - Overload for more than 256 consecutive cycles shuts channel down.
// - Hiccup: stay off 8192 switching cycles, then restart automatically.
// - Sync mode: each cycle starts on external clock falling edge.
// - Resistor-set period until an external clock is seen.
// - First high on frequency pin latches sync mode, releases pin.
// - Sync clock lost: run at 100 kHz first, then resistor period.
// - Over-temperature stops switching; restart power-up once it clears.
// - Enable low keeps the channel disabled, no switching.
// - Enable high with input good: activate and launch soft-start.
// - No operation while undervoltage lockout is asserted.
// - Output overvoltage holds high side off until a cycle start with overvoltage clear.
// - Three switching clocks spaced 120 degrees apart.
module bpsc_top
  import bpsc_pkg::*;
#(
  parameter int PERIOD_W = 16,
  parameter int OVL_LIMIT = `BPSC_OVL_LIMIT,
  parameter int HICCUP_CYC = `BPSC_HICCUP_CYC,
  parameter int FALLBACK_CYC = `BPSC_FALLBACK_CYC
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic EN,
  input wire logic UV_OK,
  input wire logic OVERTEMP,
  input wire logic OVERLOAD,
  input wire logic PEAK_HIT,
  input wire logic LS_SRC_LIM,
  input wire logic LS_SNK_LIM,
  input wire logic SENSE_OVP,
  input wire logic FSET_IN,
  input wire logic [PERIOD_W-1:0] RES_PERIOD,
  output logic FSET_OUT,
  output logic FSET_OE,
  output logic SYNC_MODE,
  output logic [2:0] PHASE_CLK,
  output logic HS_ON,
  output logic LS_ON,
  output logic SS_START,
  output logic CH_ACTIVE,
  output logic HICCUP
);
  localparam int FB_CNT = `BPSC_FALLBACK_CNT;
  localparam int LOSS_CNT = `BPSC_SYNC_LOSS_CNT;

  if (PERIOD_W < 10 || PERIOD_W > 24 || OVL_LIMIT < 1 ||
      OVL_LIMIT > 511 || HICCUP_CYC < 1 || HICCUP_CYC > 16384 ||
      FALLBACK_CYC < 0 || FALLBACK_CYC > 255 ||
      FB_CNT >= (1 << PERIOD_W) || LOSS_CNT >= (1 << PERIOD_W)) begin
    $error("bpsc_top: unsupported parameter values");
  end

  function automatic logic [PERIOD_W-1:0] third(
    input logic [PERIOD_W-1:0] p
  );
    third = p / 3;
  endfunction

  // Input synchronisers
  logic [8:0] s;
  bpsc_sync #(.W(`BPSC_NSYNC)) u_sync (
    .clk(MCLK),
    .rst(RST),
    .din({FSET_IN, EN, UV_OK, OVERTEMP, OVERLOAD, PEAK_HIT, LS_SRC_LIM,
          LS_SNK_LIM, SENSE_OVP}),
    .dout(s)
  );
  wire fset_s = s[8];
  wire en_s = s[7];
  wire uv_s = s[6];
  wire ot_s = s[5];
  wire ovl_s = s[4];
  wire peak_s = s[3];
  wire src_s = s[2];
  wire snk_s = s[1];
  wire ovp_s = s[0];

  // Timebase
  logic fset_d_q, sync_q, lost_q;
  logic [PERIOD_W-1:0] cnt_q, per_q, since_q;
  logic [7:0] fb_q;
  wire fall = fset_d_q & ~fset_s;
  wire lost_d = sync_q & ~fall & (since_q >= PERIOD_W'(LOSS_CNT - 1));
  wire [PERIOD_W-1:0] eff_per =
    (sync_q & ~lost_q) ? per_q :
    (lost_q & (fb_q != 8'h00)) ? PERIOD_W'(FB_CNT) :
    RES_PERIOD;
  wire start = (sync_q & ~lost_q) ? fall :
               (cnt_q >= eff_per - PERIOD_W'(1));
  wire ph1 = cnt_q == third(eff_per) - PERIOD_W'(1);
  wire ph2 = cnt_q == PERIOD_W'(2 * third(eff_per) - 1);

  always_ff @(posedge MCLK) begin
    if (RST) begin
      fset_d_q <= 1'b0;
      sync_q <= 1'b0;
      lost_q <= 1'b0;
      cnt_q <= '0;
      per_q <= '1;
      since_q <= '0;
      fb_q <= 8'h00;
      PHASE_CLK <= 3'h0;
      FSET_OE <= 1'b1;
      FSET_OUT <= 1'b0;
      SYNC_MODE <= 1'b0;
    end else begin
      fset_d_q <= fset_s;
      if (fset_s) begin
        sync_q <= 1'b1;
        SYNC_MODE <= 1'b1;
        FSET_OE <= 1'b0;
      end
      lost_q <= lost_d;
      since_q <= fall ? '0 : (lost_d ? since_q : since_q + PERIOD_W'(1));
      if (fall && sync_q) begin
        per_q <= cnt_q + PERIOD_W'(1);
      end
      if (lost_d && !lost_q) begin
        fb_q <= 8'(FALLBACK_CYC);
      end else if (lost_q && start && fb_q != 8'h00) begin
        fb_q <= fb_q - 8'h01;
      end
      cnt_q <= start ? '0 : cnt_q + PERIOD_W'(1);
      PHASE_CLK <= {ph2, ph1, start};
    end
  end

  // Channel supervisor
  bpsc_state_t state_q, state_d;
  logic [8:0] ovl_cnt_q;
  logic [13:0] hic_q;
  logic snk_off_q;
  wire go = en_s & uv_s & ~ot_s;
  wire ovl_trip = start & ovl_s & (ovl_cnt_q == 9'(OVL_LIMIT));
  wire hic_done = start & (hic_q == 14'(HICCUP_CYC - 1));

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_OFF: begin
        if (go) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!en_s || !uv_s) begin
          state_d = ST_OFF;
        end else if (ot_s) begin
          state_d = ST_HOT;
        end else if (ovl_trip) begin
          state_d = ST_HICCUP;
        end
      end
      ST_HICCUP: begin
        if (!en_s || !uv_s) begin
          state_d = ST_OFF;
        end else if (ot_s) begin
          state_d = ST_HOT;
        end else if (hic_done) begin
          state_d = ST_OFF;
        end
      end
      ST_HOT: begin
        if (!uv_s || !ot_s) begin
          state_d = ST_OFF;
        end
      end
      default: begin
        state_d = ST_OFF;
      end
    endcase
  end

  wire run_nxt = (state_q == ST_RUN) && (state_d == ST_RUN);
  wire hs_start = ~src_s & ~ovp_s;
  wire hs_cut = HS_ON & (peak_s | ovp_s);
  wire hs_d = run_nxt & (start ? hs_start : HS_ON & ~hs_cut);
  wire snk_hit = LS_ON & snk_s & ~start;
  wire snk_off_d = run_nxt & ~start & (snk_off_q | snk_hit);
  wire ls_d = run_nxt & ~snk_off_d &
              (start ? ~hs_start : (LS_ON | hs_cut));

  always_ff @(posedge MCLK) begin
    if (RST) begin
      state_q <= ST_OFF;
      ovl_cnt_q <= 9'h000;
      hic_q <= 14'h0000;
      snk_off_q <= 1'b0;
      HS_ON <= 1'b0;
      LS_ON <= 1'b0;
      SS_START <= 1'b0;
    end else begin
      state_q <= state_d;
      if (state_q != ST_RUN || (start && !ovl_s)) begin
        ovl_cnt_q <= 9'h000;
      end else if (start) begin
        ovl_cnt_q <= ovl_cnt_q + 9'h001;
      end
      if (state_q != ST_HICCUP) begin
        hic_q <= 14'h0000;
      end else if (start) begin
        hic_q <= hic_q + 14'h0001;
      end
      snk_off_q <= snk_off_d;
      HS_ON <= hs_d;
      LS_ON <= ls_d;
      SS_START <= (state_q == ST_OFF) && (state_d == ST_RUN);
    end
  end

  assign CH_ACTIVE = state_q[1];
  assign HICCUP = state_q[2];

  // Checks
  wire run_q = state_q == ST_RUN;
  wire [8:0] ovl_cnt_w = ovl_cnt_q;
  chk_peak_cut: assert property (@(posedge MCLK) disable iff (RST)
    run_nxt && HS_ON && peak_s && !start |=> !HS_ON && LS_ON)
    else $error("high side not cut on peak current");
  chk_src_skip: assert property (@(posedge MCLK) disable iff (RST)
    run_nxt && start && src_s |=> !HS_ON && LS_ON)
    else $error("high side not skipped on source limit");
  chk_hs_resume: assert property (@(posedge MCLK) disable iff (RST)
    $rose(HS_ON) |-> $past(start) && !$past(src_s) && !$past(ovp_s))
    else $error("high side resumed off a cycle start");
  chk_sink_hold: assert property (@(posedge MCLK) disable iff (RST)
    LS_ON && snk_s && !start |=> (!LS_ON && !HS_ON) [*2] or
    (!LS_ON && !HS_ON ##1 $past(start)))
    else $error("switches not held off after sink limit");
  chk_ovl_trip: assert property (@(posedge MCLK) disable iff (RST)
    $rose(HICCUP) |-> $past(ovl_cnt_w) == 9'(OVL_LIMIT) && $past(ovl_s))
    else $error("hiccup entered at wrong overload count");
  chk_sync_latch: assert property (@(posedge MCLK) disable iff (RST)
    fset_s ##1 1'b1 |-> SYNC_MODE && !FSET_OE)
    else $error("sync mode not latched or pin not released");
  chk_hot_stop: assert property (@(posedge MCLK) disable iff (RST)
    ot_s |=> !HS_ON && !LS_ON ##1 !HS_ON)
    else $error("switching during over-temperature");
  chk_en_off: assert property (@(posedge MCLK) disable iff (RST)
    !en_s |=> !HS_ON && !LS_ON && !CH_ACTIVE)
    else $error("switching while disabled");
  chk_ss_cause: assert property (@(posedge MCLK) disable iff (RST)
    SS_START |-> CH_ACTIVE && $past(en_s) && $past(uv_s) && !$past(run_q))
    else $error("soft-start without enable");
  chk_uvlo_off: assert property (@(posedge MCLK) disable iff (RST)
    !uv_s |=> !CH_ACTIVE && !HS_ON && !LS_ON)
    else $error("operating under lockout");
endmodule

//--- verification/bpsc_far_end.sv
`timescale 1ns/10ps
module bpsc_far_end (
  input wire logic clk,
  input wire logic hs_on,
  input wire logic ext_en,
  output logic peak_hit,
  output logic fset_in
);
  logic [5:0] ramp_q = 6'h00;
  logic [5:0] sq_q = 6'h00;
  always @(posedge clk) begin
    ramp_q <= hs_on ? ramp_q + 6'h01 : 6'h00;
    sq_q <= (sq_q == 6'h31) ? 6'h00 : sq_q + 6'h01;
  end
  // Inductor current reaches the reference after eight cycles
  assign peak_hit = (ramp_q >= 6'h08);
  // 1 MHz sync clock, 40% duty; resistor pulls pin low otherwise
  assign fset_in = ext_en && (sq_q < 6'h14);
endmodule

//--- verification/buck_protection_and_sync_control_test.sv
`timescale 1ns/10ps
module buck_protection_and_sync_control_test;
  logic mclk = 0, rst = 1, en = 0, uv_ok = 0, overtemp = 0, overload = 0;
  logic src_lim = 0, snk_lim = 0, ovp = 0, ext_en = 0;
  logic hs_seen = 0, ss_seen = 0, ph_seen = 0;
  logic [15:0] res_period = 16'h001e;
  logic peak_hit, fset_in, fset_out, fset_oe, sync_mode, hs_on, ls_on;
  logic ss_start, ch_active, hiccup;
  logic [2:0] phase_clk;
  int failures = 0, comparisons = 0, cycles = 0;
  bpsc_top #(.OVL_LIMIT(4), .HICCUP_CYC(16), .FALLBACK_CYC(2)) u_bpsc_top (
    .MCLK(mclk), .RST(rst), .EN(en), .UV_OK(uv_ok), .OVERTEMP(overtemp),
    .OVERLOAD(overload), .PEAK_HIT(peak_hit), .LS_SRC_LIM(src_lim),
    .LS_SNK_LIM(snk_lim), .SENSE_OVP(ovp), .FSET_IN(fset_in),
    .RES_PERIOD(res_period), .FSET_OUT(fset_out), .FSET_OE(fset_oe),
    .SYNC_MODE(sync_mode), .PHASE_CLK(phase_clk), .HS_ON(hs_on),
    .LS_ON(ls_on), .SS_START(ss_start), .CH_ACTIVE(ch_active),
    .HICCUP(hiccup));
  bpsc_far_end u_bpsc_far_end (.clk(mclk), .hs_on(hs_on), .ext_en(ext_en),
    .peak_hit(peak_hit), .fset_in(fset_in));
  initial forever #10 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (hs_on === 1'b1) hs_seen <= 1'b1;
    if (ss_start === 1'b1) ss_seen <= 1'b1;
    if (phase_clk[0] === 1'b1) ph_seen <= 1'b1;
    if (cycles == 20000) begin
      failures = failures + 1;
      complete_run();
    end
  end
  task complete_run();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task check(input string name, input logic [15:0] seen,
             input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task wait_hs();
    for (int i = 0; i < 100 && hs_on !== 1'b1; i++) step(1);
  endtask
  task t_enable();
    check("fset_oe", fset_oe, 16'h1);
    check("ch_active", ch_active, 16'h0);
    check("reset_out", {fset_out, sync_mode, hs_on, ls_on, hiccup,
          ss_start}, 16'h0);
    en = 1;
    uv_ok = 1;
    step(10);
    check("ss_start", ss_seen, 16'h1);
    check("ch_active", ch_active, 16'h1);
  endtask
  task t_peak_sink();
    wait_hs();
    step(14);
    check("hs_on", hs_on, 16'h0);
    check("ls_on", ls_on, 16'h1);
    snk_lim = 1;
    step(1);
    snk_lim = 0;
    step(4);
    check("both", {hs_on, ls_on}, 16'h0);
  endtask
  task t_block();
    for (int k = 0; k < 2; k++) begin
      if (k == 0) src_lim = 1;
      else ovp = 1;
      step(40);
      hs_seen = 0;
      step(90);
      check("hs_blocked", hs_seen, 16'h0);
      src_lim = 0;
      ovp = 0;
      step(70);
      check("hs_resumed", hs_seen, 16'h1);
    end
  endtask
  task t_hiccup();
    overload = 1;
    step(500);
    check("hiccup", hiccup, 16'h1);
    check("hs_on", hs_on, 16'h0);
    overload = 0;
    step(250);
    check("restart", {hiccup, ch_active}, 16'h1);
  endtask
  task t_off_states();
    overtemp = 1;
    step(5);
    hs_seen = 0;
    step(60);
    check("hot_hs", hs_seen, 16'h0);
    ss_seen = 0;
    overtemp = 0;
    step(40);
    check("hot_restart", ss_seen, 16'h1);
    en = 0;
    step(5);
    hs_seen = 0;
    step(60);
    check("en_low", {hs_seen, ch_active}, 16'h0);
    en = 1;
    step(10);
    uv_ok = 0;
    step(5);
    check("uv_low", {hs_on, ls_on, ch_active}, 16'h0);
    uv_ok = 1;
    step(10);
  endtask
  task t_sync();
    check("sync_mode", sync_mode, 16'h0);
    ext_en = 1;
    step(60);
    check("sync_mode", sync_mode, 16'h1);
    check("fset_oe", fset_oe, 16'h0);
    check("fset_out", fset_out, 16'h0);
    for (int i = 0; i < 100 && fset_in !== 1'b1; i++) step(1);
    for (int i = 0; i < 100 && fset_in !== 1'b0; i++) step(1);
    ph_seen = 0;
    step(3);
    check("sync_edge", phase_clk[0], 16'h1);
    step(3);
    check("sync_start", ph_seen, 16'h1);
  endtask
  task t_phase();
    for (int i = 0; i < 100 && phase_clk[0] !== 1'b1; i++) step(1);
    step(res_period / 3);
    check("phase_b", phase_clk, 16'h2);
    step(res_period / 3);
    check("phase_c", phase_clk, 16'h4);
    step(res_period / 3);
    check("phase_a", phase_clk, 16'h1);
  endtask
  task t_ovl_clear();
    for (int k = 0; k < 2; k++) begin
      overload = 1;
      step(100);
      overload = 0;
      step(40);
    end
    check("ovl_clear", {hiccup, ch_active}, 16'h1);
  endtask
  task next_start(output int n);
    n = 1;
    step(1);
    while (n < 1000 && phase_clk[0] !== 1'b1) begin
      n++;
      step(1);
    end
  endtask
  task t_sync_loss();
    int n;
    ext_en = 0;
    step(10);
    next_start(n);
    next_start(n);
    check("fallback_gap", 16'(n), 16'(50000000 / 100000));
    next_start(n);
    check("resistor_gap", 16'(n), res_period);
    check("sync_sticky", sync_mode, 16'h1);
  endtask
  initial begin
    step(16);
    rst = 0;
    step(3);
    t_enable();
    t_phase();
    t_peak_sink();
    t_block();
    t_ovl_clear();
    t_hiccup();
    t_off_states();
    t_sync();
    t_sync_loss();
    complete_run();
  end
endmodule
